// file: aa_annunciator.sv
// run-mode alarm and display annunciator with wishbone registers
//
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/1ns
// How it works
// - upper line always oxygen; display press steps lower line to next enabled item.
// - probe below validity temperature shows under-temperature message on lower line.
// - calibration gas 1 or 2, or purge, in progress shows its message.
// - run-hour counter advances only while fuel valve contact reads closed.
// - a service day change restarts the run-hour counter from zero.
// - each alarm press shows the next active alarm on lower line.
// - alarms already cleared are skipped when the sequence is stepped.
// - accepted tag shows only on an active alarm already displayed once.
// - press after last active alarm returns to the saved variable.
// - lamp flashes on new alarm; press makes it steady or off.
// - horn latches on any new alarm, press mutes it.
// - sensor failure on high impedance, suppressed while probe is cold.
// - first twenty heater minutes suppress heater failure, drive undertemp relay while probe is cold.
// - heater on past twenty minutes and still cold raises heater failure.
// - open thermocouple raises its alarm and switches the heater off.
// - reference pump off three seconds every ten minutes; flow switch checked.
// - output converter check and its alarm only on auto-calibrate press.
// - blocked-filter test only when auto purge configured and requested.
// - separate calibration error alarm for each calibration gas.
// - probe-not-ready relay follows cold probe, non-latching.
// - burner bypass switch on raises heater bypass alarm.
// - watchdog lights error lamp and common relay, not shown in sequence.
module aa_annunciator #(
	parameter int CYC_PER_MS = aa_pkg::CYC_PER_MS,
	parameter int MS_PER_S   = aa_pkg::MS_PER_S
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// operator buttons, debounced levels
	input  wire logic        displayBtn,
	input  wire logic        alarmBtn,
	input  wire logic        autoCalBtn,
	// measurement and plant conditions
	input  wire logic        probeCold,
	input  wire logic        cellImpHigh,
	input  wire logic        tcOpen,
	input  wire logic        refAirLow,
	input  wire logic        flowPresent,
	input  wire logic        adCalFault,
	input  wire logic        daCalFault,
	input  wire logic        purgeFlowLow,
	input  wire logic        gas1Mismatch,
	input  wire logic        gas2Mismatch,
	input  wire logic        cal1Active,
	input  wire logic        cal2Active,
	input  wire logic        purgeActive,
	input  wire logic        fuelValveClosed,
	input  wire logic        bypassOn,
	input  wire logic        watchdogTimeout,
	input  wire logic        heaterOn,
	input  wire logic        serviceDayChanged,
	// display
	output logic             upperShowsOxygen,
	output logic      [4:0]  lowerCode,
	output logic      [3:0]  lowerAlarmIdx,
	output logic             accepted_tag,
	// lamps and relays
	output logic             alarmLamp,
	output logic             errorLamp,
	output logic             horn_relay,
	output logic             common_alarm_relay,
	output logic             probe_not_ready_relay,
	output logic             cal_in_progress_relay,
	output logic             heater_undertemp_relay,
	output logic             heaterEnable,
	output logic             refAirPumpOn
);
	localparam int NPIN = 21;
	localparam int NA   = aa_pkg::NUM_ALARMS;

	initial begin
		if (CYC_PER_MS < 1 || CYC_PER_MS > 131072 || MS_PER_S < 2 ||
			MS_PER_S > 1024) begin
			$error("aa_annunciator: tick parameters out of range");
		end
	end

	// ----------------------------------------------------------------
	// pin synchronisation
	// ----------------------------------------------------------------
	logic [NPIN-1:0] pinRaw;
	logic [NPIN-1:0] pinS;

	assign pinRaw = {displayBtn, alarmBtn, autoCalBtn, probeCold,
		cellImpHigh, tcOpen, refAirLow, flowPresent, adCalFault,
		daCalFault, purgeFlowLow, gas1Mismatch, gas2Mismatch, cal1Active,
		cal2Active, purgeActive, fuelValveClosed, bypassOn,
		watchdogTimeout, heaterOn, serviceDayChanged};

	aa_sync #(.W(NPIN)) uSync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.asyncIn (pinRaw),
		.syncOut (pinS)
	);

	wire sDisp   = pinS[20];
	wire sAlarm  = pinS[19];
	wire sAuto   = pinS[18];
	wire sCold   = pinS[17];
	wire sImp    = pinS[16];
	wire sTcOpen = pinS[15];
	wire sRefLow = pinS[14];
	wire sFlow   = pinS[13];
	wire sAdF    = pinS[12];
	wire sDaF    = pinS[11];
	wire sPgLow  = pinS[10];
	wire sGas1   = pinS[9];
	wire sGas2   = pinS[8];
	wire sCal1   = pinS[7];
	wire sCal2   = pinS[6];
	wire sPurge  = pinS[5];
	wire sFuel   = pinS[4];
	wire sBypass = pinS[3];
	wire sWdog   = pinS[2];
	wire sHeater = pinS[1];
	wire sSvc    = pinS[0];

	logic dispPrev;
	logic alarmPrev;
	logic autoPrev;
	logic purgePrev;
	logic svcPrev;

	wire dispPress  = sDisp & ~dispPrev;
	wire alarmPress = sAlarm & ~alarmPrev;
	wire autoPress  = sAuto & ~autoPrev;
	wire purgeStart = sPurge & ~purgePrev;
	wire svcPulse   = sSvc & ~svcPrev;

	// ----------------------------------------------------------------
	// time base
	// ----------------------------------------------------------------
	logic msTick;
	logic secTick;
	logic flashTick;

	aa_tick #(.W(17), .DIV(CYC_PER_MS)) uMs (
		.clk_sys (clk_sys),
		.rst     (rst),
		.en      (1'b1),
		.tick    (msTick)
	);

	aa_tick #(.W(10), .DIV(MS_PER_S)) uSec (
		.clk_sys (clk_sys),
		.rst     (rst),
		.en      (msTick),
		.tick    (secTick)
	);

	// fixed rate: operators expect the same flash on every unit
	aa_tick #(.W(10), .DIV(aa_pkg::FLASH_HALF_MS)) uFlash (
		.clk_sys (clk_sys),
		.rst     (rst),
		.en      (msTick),
		.tick    (flashTick)
	);

	// ----------------------------------------------------------------
	// configuration and decode functions
	// ----------------------------------------------------------------
	logic [13:0] cfgMask;
	logic        cfgAutoPurge;

	function automatic logic [3:0] nextVar(input logic [3:0] cur,
		input logic [13:0] mask);
		logic [3:0] res;
		logic       found;
		int         c;
		res   = cur;
		found = 1'b0;
		for (int i = 1; i <= aa_pkg::NUM_VARS; i++) begin
			c = (int'(cur) + i) % aa_pkg::NUM_VARS;
			if (!found && mask[c]) begin
				res   = 4'(c);
				found = 1'b1;
			end
		end
		return res;
	endfunction

	// {found, index} of next active alarm after ptr, or from the top
	function automatic logic [4:0] nextAlarm(input logic [3:0] ptr,
		input logic fromTop, input logic [NA-1:0] act);
		logic [4:0] res;
		res = 5'h00;
		for (int i = NA - 1; i >= 0; i--) begin
			if (act[i] && (fromTop || i > int'(ptr))) begin
				res = {1'b1, 4'(i)};
			end
		end
		return res;
	endfunction

	// ----------------------------------------------------------------
	// alarm conditions
	// ----------------------------------------------------------------
	logic [10:0] warmSec;
	logic [9:0]  refSec;
	logic        flowFault;
	logic        daErr;
	logic        filterErr;
	logic [NA-1:0] actPrev;
	logic [NA-1:0] act;

	wire warmUp   = sHeater & (warmSec < 11'(aa_pkg::WARMUP_S));
	wire pumpOff  = refSec >= 10'(aa_pkg::REFTEST_PERIOD_S -
		aa_pkg::REFTEST_OFF_S);
	wire refCheck = secTick &
		(refSec == 10'(aa_pkg::REFTEST_PERIOD_S - 1));
	wire filterSet = cfgAutoPurge & sPurge & sPgLow;

	always_comb begin
		act = '0;
		act[aa_pkg::AL_SENSOR_FAIL] = sImp & ~sCold;
		act[aa_pkg::AL_HEATER_FAIL] = sHeater & ~warmUp & sCold;
		act[aa_pkg::AL_TC_OPEN]     = sTcOpen;
		act[aa_pkg::AL_REF_AIR]     = sRefLow;
		act[aa_pkg::AL_FLOW_SWITCH] = flowFault;
		act[aa_pkg::AL_AD_CAL]      = sAdF;
		act[aa_pkg::AL_DA_CAL]      = daErr;
		act[aa_pkg::AL_FILTER]      = filterErr;
		act[aa_pkg::AL_GAS1_CAL]    = sGas1;
		act[aa_pkg::AL_GAS2_CAL]    = sGas2;
		act[aa_pkg::AL_BYPASS]      = sBypass;
	end

	wire newAlarm = |(act & ~actPrev);
	wire anyAct   = |act;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			warmSec <= '0;
		end else if (!sHeater) begin
			warmSec <= '0;
		end else if (secTick && warmUp) begin
			warmSec <= warmSec + 1'b1;
		end
	end

	// flow switch must drop while the pump is stopped
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			refSec    <= '0;
			flowFault <= 1'b0;
		end else if (secTick) begin
			if (refCheck) begin
				refSec    <= '0;
				flowFault <= sFlow;
			end else begin
				refSec <= refSec + 1'b1;
			end
		end
	end

	// latched results cleared only by the next run of their test
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			daErr     <= 1'b0;
			filterErr <= 1'b0;
		end else begin
			if (autoPress) begin
				daErr <= sDaF;
			end
			if (filterSet) begin
				filterErr <= 1'b1;
			end else if (purgeStart) begin
				filterErr <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// alarm stepping, lamp and horn
	// ----------------------------------------------------------------
	logic        alarmMode;
	logic        accNow;
	logic [3:0]  alarmPtr;
	logic [NA-1:0] seen;
	logic [3:0]  varIdx;
	aa_pkg::aa_lamp_e lamp;
	aa_pkg::aa_lamp_e next_lamp;

	wire [4:0] nxt = nextAlarm(alarmPtr, ~alarmMode, act);

	always_comb begin
		next_lamp = lamp;
		case (lamp)
			aa_pkg::AA_LAMP_OFF,
			aa_pkg::AA_LAMP_FLASH,
			aa_pkg::AA_LAMP_STEADY: begin
				if (newAlarm) begin
					next_lamp = aa_pkg::AA_LAMP_FLASH;
				end else if (alarmPress) begin
					next_lamp = anyAct ? aa_pkg::AA_LAMP_STEADY
						: aa_pkg::AA_LAMP_OFF;
				end
			end
			default: next_lamp = aa_pkg::AA_LAMP_OFF;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			alarmMode <= 1'b0;
			alarmPtr  <= '0;
			accNow    <= 1'b0;
		end else if (alarmPress) begin
			if (nxt[4]) begin
				alarmMode <= 1'b1;
				alarmPtr  <= nxt[3:0];
				accNow    <= seen[nxt[3:0]];
			end else begin
				alarmMode <= 1'b0;
				accNow    <= 1'b0;
			end
		end
	end

	// a display mark is dropped as soon as its alarm clears
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			seen <= '0;
		end else begin
			for (int i = 0; i < NA; i++) begin
				if (alarmPress && nxt[4] && nxt[3:0] == 4'(i)) begin
					seen[i] <= act[i];
				end else begin
					seen[i] <= seen[i] & act[i];
				end
			end
		end
	end

	// new alarm beats a press in the same cycle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lamp       <= aa_pkg::AA_LAMP_OFF;
			horn_relay <= 1'b0;
			alarmLamp  <= 1'b0;
			actPrev    <= '0;
		end else begin
			lamp    <= next_lamp;
			actPrev <= act;
			if (newAlarm) begin
				horn_relay <= 1'b1;
			end else if (alarmPress) begin
				horn_relay <= 1'b0;
			end
			if (lamp == aa_pkg::AA_LAMP_FLASH) begin
				alarmLamp <= flashTick ? ~alarmLamp : alarmLamp;
			end else begin
				alarmLamp <= (lamp == aa_pkg::AA_LAMP_STEADY);
			end
		end
	end

	// ----------------------------------------------------------------
	// display selection
	// ----------------------------------------------------------------
	wire [4:0] next_lowerCode =
		alarmMode ? aa_pkg::LC_ALARM :
		sCal1     ? aa_pkg::LC_CAL1 :
		sCal2     ? aa_pkg::LC_CAL2 :
		sPurge    ? aa_pkg::LC_PURGE :
		sCold     ? aa_pkg::LC_UNDERTEMP :
		{1'b0, varIdx};

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			varIdx           <= aa_pkg::VAR_RST;
			lowerCode        <= 5'h00;
			lowerAlarmIdx    <= 4'h0;
			upperShowsOxygen <= 1'b0;
			accepted_tag     <= 1'b0;
		end else begin
			if (dispPress) begin
				varIdx <= nextVar(varIdx, cfgMask);
			end
			upperShowsOxygen <= 1'b1;
			lowerCode        <= next_lowerCode;
			lowerAlarmIdx    <= alarmPtr;
			// tag moves with the lower line so both change on one edge
			accepted_tag     <= accNow;
		end
	end

	// ----------------------------------------------------------------
	// relays, heater, pump, run hours
	// ----------------------------------------------------------------
	logic [11:0] hourSec;
	logic [15:0] runHours;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			errorLamp              <= 1'b0;
			common_alarm_relay     <= 1'b0;
			probe_not_ready_relay  <= 1'b0;
			cal_in_progress_relay  <= 1'b0;
			heater_undertemp_relay <= 1'b0;
			heaterEnable           <= 1'b0;
			refAirPumpOn           <= 1'b0;
		end else begin
			errorLamp              <= sWdog;
			common_alarm_relay     <= anyAct | sWdog;
			probe_not_ready_relay  <= sCold;
			cal_in_progress_relay  <= sCal1 | sCal2 | sPurge;
			heater_undertemp_relay <= warmUp & sCold;
			heaterEnable           <= sHeater & ~sTcOpen;
			refAirPumpOn           <= ~pumpOff;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			hourSec  <= '0;
			runHours <= '0;
		end else if (svcPulse) begin
			hourSec  <= '0;
			runHours <= '0;
		end else if (secTick && sFuel) begin
			if (hourSec == 12'(aa_pkg::S_PER_HOUR - 1)) begin
				hourSec  <= '0;
				runHours <= runHours + 1'b1;
			end else begin
				hourSec <= hourSec + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// wishbone register file
	// ----------------------------------------------------------------
	wire        wbReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire        selCfg  = wb_adr_i == aa_pkg::REG_CFG;
	wire        selSt   = wb_adr_i == aa_pkg::REG_STATUS;
	wire        selHrs  = wb_adr_i == aa_pkg::REG_RUNHRS;
	wire        selDisp = wb_adr_i == aa_pkg::REG_DISPLAY;
	wire [31:0] cfgWord = {15'h0000, cfgAutoPurge, 2'b00, cfgMask};
	wire [31:0] stWord  = {15'h0000, sWdog, 5'h00, act};
	wire [31:0] dspWord = {20'h00000, alarmMode, accepted_tag,
		lowerAlarmIdx, 1'b0, lowerCode};
	wire [31:0] rdWord  = selCfg  ? cfgWord :
		selSt   ? stWord :
		selHrs  ? {16'h0000, runHours} :
		selDisp ? dspWord : 32'h00000000;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wb_ack_o     <= 1'b0;
			wb_dat_o     <= '0;
			cfgMask      <= aa_pkg::CFG_MASK_RST;
			cfgAutoPurge <= aa_pkg::CFG_PURGE_RST;
		end else begin
			wb_ack_o <= wbReq;
			wb_dat_o <= (wbReq && !wb_we_i) ? rdWord : 32'h00000000;
			if (wbReq && wb_we_i && selCfg) begin
				if (wb_sel_i[0]) begin
					cfgMask[7:0] <= wb_dat_i[7:0];
				end
				if (wb_sel_i[1]) begin
					cfgMask[13:8] <= wb_dat_i[13:8];
				end
				if (wb_sel_i[2]) begin
					cfgAutoPurge <= wb_dat_i[aa_pkg::CFG_PURGE_BIT];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// edge history
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dispPrev  <= 1'b0;
			alarmPrev <= 1'b0;
			autoPrev  <= 1'b0;
			purgePrev <= 1'b0;
			svcPrev   <= 1'b0;
		end else begin
			dispPrev  <= sDisp;
			alarmPrev <= sAlarm;
			autoPrev  <= sAuto;
			purgePrev <= sPurge;
			svcPrev   <= sSvc;
		end
	end
endmodule

// file: aa_annunciator_properties.sv
// port assertions for the alarm annunciator
`timescale 1ns/1ns
module aa_annunciator_chk (
	// clock and reset
	input wire logic       clk_sys,
	input wire logic       rst,
	// watched ports
	input wire logic       probeCold,
	input wire logic       tcOpen,
	input wire logic       bypassOn,
	input wire logic       watchdogTimeout,
	input wire logic       upperShowsOxygen,
	input wire logic [4:0] lowerCode,
	input wire logic       accepted_tag,
	input wire logic       errorLamp,
	input wire logic       common_alarm_relay,
	input wire logic       probe_not_ready_relay,
	input wire logic       heater_undertemp_relay,
	input wire logic       heaterEnable
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// inputs cross two sync flops and an output flop: three cycles settle, checked after five
	property p_upper; upperShowsOxygen |=> upperShowsOxygen; endproperty
	a_upper: assert property (p_upper) else $error("oxygen lost");
	property p_pnr_on; probeCold[*5] |-> probe_not_ready_relay; endproperty
	a_pnr_on: assert property (p_pnr_on) else $error("relay off");
	property p_pnr_off; !probeCold[*5] |-> !probe_not_ready_relay; endproperty
	a_pnr_off: assert property (p_pnr_off) else $error("relay on");
	property p_tc; tcOpen[*5] |-> !heaterEnable; endproperty
	a_tc: assert property (p_tc) else $error("heater on");
	property p_wdog; watchdogTimeout[*5] |-> errorLamp && common_alarm_relay;
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog unseen");
	property p_byp; bypassOn[*5] |-> common_alarm_relay; endproperty
	a_byp: assert property (p_byp) else $error("bypass unseen");
	property p_under; heater_undertemp_relay |-> probe_not_ready_relay;
	endproperty
	a_under: assert property (p_under) else $error("undertemp warm");
	property p_acc; accepted_tag |-> lowerCode == aa_pkg::LC_ALARM; endproperty
	a_acc: assert property (p_acc) else $error("stray tag");
	c_acc: cover property (accepted_tag);
	c_under: cover property (heater_undertemp_relay);
	c_alarm: cover property (lowerCode == aa_pkg::LC_ALARM);
endmodule
bind aa_annunciator aa_annunciator_chk u_chk (
	.clk_sys(clk_sys), .rst(rst), .probeCold(probeCold), .tcOpen(tcOpen),
	.bypassOn(bypassOn), .watchdogTimeout(watchdogTimeout),
	.upperShowsOxygen(upperShowsOxygen), .lowerCode(lowerCode),
	.accepted_tag(accepted_tag), .errorLamp(errorLamp),
	.common_alarm_relay(common_alarm_relay),
	.probe_not_ready_relay(probe_not_ready_relay),
	.heater_undertemp_relay(heater_undertemp_relay),
	.heaterEnable(heaterEnable));

// file: aa_panel.sv
// operator panel and reference air flow switch model
`timescale 1ns/1ns
module aa_panel (
	// clock
	input  wire logic       clk_sys,
	// bench requests and pump drive
	input  wire logic [2:0] req,
	input  wire logic       pumpOn,
	input  wire logic       stuck,
	// buttons and flow switch
	output logic      [2:0] btn = 3'h0,
	output logic            flow
);
	logic [2:0] lag  = 3'h0;
	logic [2:0] hold = 3'h0;
	// ----------------------------------------------------------------
	// press held several cycles so the synchroniser cannot miss it
	// ----------------------------------------------------------------
	always @(posedge clk_sys) begin
		lag <= {lag[1:0], pumpOn};
		if (req != 3'h0) begin
			btn <= req;
			hold <= 3'h6;
		end else if (hold != 3'h0)
			hold <= hold - 3'h1;
		else
			btn <= 3'h0;
	end
	// stuck switch keeps reporting flow with the pump stopped
	assign flow = stuck | lag[2];
endmodule

// file: aa_pkg.sv
// constants, field layouts and types for the alarm annunciator
package aa_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ             = 125_000_000;
	localparam int CYC_PER_MS         = CLK_HZ / 1000;
	localparam int MS_PER_S           = 1000;
	localparam int WARMUP_MIN         = 20;
	localparam int WARMUP_S           = WARMUP_MIN * 60;
	localparam int REFTEST_PERIOD_MIN = 10;
	localparam int REFTEST_PERIOD_S   = REFTEST_PERIOD_MIN * 60;
	localparam int REFTEST_OFF_S      = 3;
	localparam int FLASH_HZ           = 1;
	localparam int FLASH_HALF_MS      = 1000 / (2 * FLASH_HZ);
	localparam int S_PER_HOUR         = 3600;

	// ----------------------------------------------------------------
	// alarm positions in the active vector, in display order
	// ----------------------------------------------------------------
	localparam int NUM_ALARMS     = 11;
	localparam int AL_SENSOR_FAIL = 0;
	localparam int AL_HEATER_FAIL = 1;
	localparam int AL_TC_OPEN     = 2;
	localparam int AL_REF_AIR     = 3;
	localparam int AL_FLOW_SWITCH = 4;
	localparam int AL_AD_CAL      = 5;
	localparam int AL_DA_CAL      = 6;
	localparam int AL_FILTER      = 7;
	localparam int AL_GAS1_CAL    = 8;
	localparam int AL_GAS2_CAL    = 9;
	localparam int AL_BYPASS      = 10;

	// ----------------------------------------------------------------
	// lower line codes: 0..13 variables, 15..19 messages
	// ----------------------------------------------------------------
	localparam int         NUM_VARS     = 14;
	localparam logic [4:0] LC_UNDERTEMP = 5'h0F;
	localparam logic [4:0] LC_CAL1      = 5'h10;
	localparam logic [4:0] LC_CAL2      = 5'h11;
	localparam logic [4:0] LC_PURGE     = 5'h12;
	localparam logic [4:0] LC_ALARM     = 5'h13;

	// ----------------------------------------------------------------
	// register map, byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0]  REG_CFG      = 8'h00;
	localparam logic [7:0]  REG_STATUS   = 8'h04;
	localparam logic [7:0]  REG_RUNHRS   = 8'h08;
	localparam logic [7:0]  REG_DISPLAY  = 8'h0C;
	localparam int          CFG_PURGE_BIT = 16;
	localparam int          ST_WDOG_BIT   = 16;
	localparam logic [13:0] CFG_MASK_RST  = 14'h3FFE;
	localparam logic        CFG_PURGE_RST = 1'b0;
	localparam logic [3:0]  VAR_RST       = 4'h1;

	typedef enum logic [2:0] {
		AA_LAMP_OFF    = 3'b001,
		AA_LAMP_FLASH  = 3'b010,
		AA_LAMP_STEADY = 3'b100
	} aa_lamp_e;

endpackage

// file: aa_sync.sv
// two-stage synchroniser for a vector of independent pin levels
`timescale 1ns/1ns
module aa_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst,
	// levels
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] syncOut
);
	logic [W-1:0] stage1;

	initial begin
		if (W < 1) begin
			$error("aa_sync: W must be at least 1");
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stage1  <= '0;
			syncOut <= '0;
		end else begin
			stage1  <= asyncIn;
			syncOut <= stage1;
		end
	end
endmodule

// file: aa_tb.sv
// self-checking bench for the alarm annunciator
`timescale 1ns/1ns
module tb;
	logic        clk_sys = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0, q, rdat;
	logic [2:0]  req = 3'h0, btn;
	logic        cold = 1'b0, imp = 1'b0, tc = 1'b0, c1 = 1'b0, c2 = 1'b0;
	logic        pg = 1'b0, pfl = 1'b0, g1 = 1'b0, g2 = 1'b0, fuel = 1'b0;
	logic        byp = 1'b0, wd = 1'b0, htr = 1'b0, sdc = 1'b0, da = 1'b0;
	logic        stuck = 1'b0, flow, ack, ox, acc, lamp, elamp, horn, com;
	logic        pnr, cip, hur, hen, pump;
	logic [4:0]  lc;
	logic [3:0]  idx;
	int          n_fail = 0, n_compared = 0;
	always #4 clk_sys = ~clk_sys;
	aa_annunciator #(.CYC_PER_MS(2), .MS_PER_S(2)) u_dut (
		.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .displayBtn(btn[0]),
		.alarmBtn(btn[1]), .autoCalBtn(btn[2]), .probeCold(cold),
		.cellImpHigh(imp), .tcOpen(tc), .refAirLow(1'b0), .flowPresent(flow),
		.adCalFault(1'b0), .daCalFault(da), .purgeFlowLow(pfl),
		.gas1Mismatch(g1), .gas2Mismatch(g2), .cal1Active(c1),
		.cal2Active(c2), .purgeActive(pg), .fuelValveClosed(fuel),
		.bypassOn(byp), .watchdogTimeout(wd), .heaterOn(htr),
		.serviceDayChanged(sdc), .upperShowsOxygen(ox), .lowerCode(lc),
		.lowerAlarmIdx(idx), .accepted_tag(acc), .alarmLamp(lamp),
		.errorLamp(elamp), .horn_relay(horn), .common_alarm_relay(com),
		.probe_not_ready_relay(pnr), .cal_in_progress_relay(cip),
		.heater_undertemp_relay(hur), .heaterEnable(hen),
		.refAirPumpOn(pump));
	aa_panel u_panel (.clk_sys(clk_sys), .req(req), .pumpOn(pump),
		.stuck(stuck), .btn(btn), .flow(flow));
	task conclude;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		we <= w;
		adr <= a;
		wdat <= d;
		cyc <= 1'b1;
		do begin
			@(posedge clk_sys);
			k++;
		end while (ack !== 1'b1 && k < 20);
		q = rdat;
		cyc <= 1'b0;
		if (ack !== 1'b1) begin
			n_fail++;
			conclude();
		end
		@(posedge clk_sys);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task press(input logic [2:0] b);
		req <= b;
		wt(1);
		req <= 3'h0;
		wt(14);
	endtask
	task t_regs;
		rd(8'h00, 32'h3FFE);
		rd(8'h20, 32'h0);
		chk(ox, 1'b1);
		wb(1'b1, 8'h00, 32'h9);
		rd(8'h00, 32'h9);
		press(3'h1);
		chk(lc, 5'h03);
		press(3'h1);
		chk(lc, 5'h00);
		press(3'h1);
		chk(lc, 5'h03);
	endtask
	task t_cold;
		cold <= 1'b1;
		wt(6);
		chk({lc, pnr}, {5'h0F, 1'b1});
		for (int i = 0; i < 3; i++) begin
			{pg, c2, c1} <= 3'b001 << i;
			wt(6);
			chk({lc, cip}, {5'h10 + 5'(i), 1'b1});
		end
		{pg, c2, c1, cold} <= 4'h0;
		wt(6);
		chk({lc, pnr}, {5'h03, 1'b0});
	endtask
	task t_alarm;
		logic b;
		{cold, imp, tc, byp, htr} <= 5'h1F;
		wt(6);
		rd(8'h04, 32'h404);
		chk({horn, hen, hur}, 3'b101);
		cold <= 1'b0;
		wt(6);
		rd(8'h04, 32'h405);
		press(3'h2);
		chk({lc, idx, acc, horn, lamp}, {9'h130, 3'b001});
		press(3'h2);
		chk({lc, idx, acc}, {9'h132, 1'b0});
		press(3'h2);
		chk({lc, idx, acc}, {9'h13A, 1'b0});
		press(3'h2);
		chk(lc, 5'h03);
		byp <= 1'b0;
		wt(6);
		press(3'h2);
		chk({lc, idx, acc}, {9'h130, 1'b1});
		rd(8'h0C, 32'hC13);
		press(3'h2);
		chk({lc, idx, acc}, {9'h132, 1'b1});
		press(3'h2);
		chk(lc, 5'h03);
		{imp, tc} <= 2'b00;
		wt(6);
		chk(hen, 1'b1);
		press(3'h2);
		chk(lamp, 1'b0);
		byp <= 1'b1;
		wt(6);
		chk(horn, 1'b1);
		b = ~lamp;
		wt(1000);
		chk(lamp, b);
		{byp, wd} <= 2'b01;
		wt(6);
		rd(8'h04, 32'h10000);
		chk({elamp, com}, 2'b11);
		wd <= 1'b0;
	endtask
	task t_hours;
		fuel <= 1'b1;
		wt(14800);
		rd(8'h08, 32'h1);
		sdc <= 1'b1;
		wt(6);
		rd(8'h08, 32'h0);
		{sdc, fuel} <= 2'b00;
	endtask
	task t_flow;
		int k;
		stuck <= 1'b1;
		k = 0;
		while (pump === 1'b1 && k < 2500) begin
			wt(1);
			k++;
		end
		if (pump === 1'b1) begin
			n_fail++;
			conclude();
		end
		k = 0;
		while (pump !== 1'b1 && k < 50) begin
			wt(1);
			k++;
		end
		if (pump !== 1'b1) begin
			n_fail++;
			conclude();
		end
		chk(k, 12);
		wt(6);
		rd(8'h04, 32'h10);
	endtask
	task t_warm;
		htr <= 1'b0;
		wt(6);
		{cold, htr} <= 2'b11;
		wt(6);
		chk(hur, 1'b1);
		wt(4700);
		rd(8'h04, 32'h10);
		wt(150);
		rd(8'h04, 32'h12);
		{cold, htr} <= 2'b00;
	endtask
	task t_checks;
		da <= 1'b1;
		wt(6);
		rd(8'h04, 32'h10);
		press(3'h4);
		rd(8'h04, 32'h50);
		{pg, pfl} <= 2'b11;
		wt(6);
		rd(8'h04, 32'h50);
		wb(1'b1, 8'h00, 32'h10009);
		wt(6);
		rd(8'h04, 32'hD0);
		g1 <= 1'b1;
		wt(6);
		rd(8'h04, 32'h1D0);
		g2 <= 1'b1;
		wt(6);
		rd(8'h04, 32'h3D0);
	endtask
	initial begin
		wt(40000);
		n_fail++;
		conclude();
	end
	initial begin
		wt(4);
		rst <= 1'b0;
		wt(2);
		t_regs();
		t_cold();
		t_alarm();
		t_hours();
		t_flow();
		t_warm();
		t_checks();
		conclude();
	end
endmodule

// file: aa_tick.sv
// divider: one-cycle pulse after every DIV input enables
`timescale 1ns/1ns
module aa_tick #(
	parameter int W   = 17,
	parameter int DIV = 125000
) (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// enable in, pulse out
	input  wire logic en,
	output logic      tick
);
	localparam logic [W-1:0] LAST = W'(DIV - 1);
	logic [W-1:0] count;

	initial begin
		if (DIV < 1 || DIV > (2 ** W)) begin
			$error("aa_tick: DIV does not fit in W bits");
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			count <= '0;
			tick  <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (en) begin
				if (count == LAST) begin
					count <= '0;
					tick  <= 1'b1;
				end else begin
					count <= count + 1'b1;
				end
			end
		end
	end
endmodule
